// file: inc/bcd_port_map.svh
`ifndef BCD_PORT_MAP_SVH
`define BCD_PORT_MAP_SVH
// Timing
`define CLK_PERIOD_NS        10
`define STROBE_TIME_US       200
`define STROBE_CYCLES        ((`STROBE_TIME_US * 1000) / `CLK_PERIOD_NS)
// Selector codes
`define SEL_DISABLED         3'h0
`define SEL_RATE             3'h1
`define SEL_AVG              3'h2
`define SEL_TOTAL            3'h3
`define SEL_TIME             3'h4
// Digit layout
`define DIGITS               6
`define DIGIT_BITS           4
`define HALF_BITS            12
`define DP_BITS              3
`endif

// file: inc/bcd_port_pkg.sv
package bcd_port_pkg;
   typedef logic [23:0] bcd_word_t;
   typedef logic [2:0]  dp_code_t;
   typedef enum logic {MODE_RATE_SQRT, MODE_BATCH} meter_mode_t;
endpackage : bcd_port_pkg

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
// Three flip-flop input synchroniser; changes once stages two and three agree
module pin_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic pin,
   output logic      level
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   // Next state
   always_comb begin
      next_stage = {stage[1:0], pin};
      next_level = (stage[2] == stage[1]) ? stage[1] : level;
   end

   // Registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         stage <= {3{INIT}};
         level <= INIT;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end
endmodule : pin_sync

// file: rtl/strobe_timer.sv
`timescale 1ns/10ps
// Active-low strobe held for a fixed count after each start pulse
module strobe_timer #(
   parameter int CYCLES = 20000
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic start,
   output logic      strobe_n
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_strobe_n;

   // Reload on start, count down otherwise
   always_comb begin
      next_count = count;
      if (start) begin
         next_count = W'(CYCLES - 1);
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
      next_strobe_n = !(start || (count != '0));
   end

   // Registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         count    <= '0;
         strobe_n <= 1'b1;
      end else begin
         count    <= next_count;
         strobe_n <= next_strobe_n;
      end
   end
endmodule : strobe_timer

// file: rtl/parallel_bcd_output_port.sv
// Function
// - selector picks value; zero disables output
// - freeze line low holds outputs unchanged
// - on release all digits refresh together
// - all digits change on one update
// - update strobe low about 200 us
// - strobe stays active low regardless polarity
// - overflow line driven only when fitted
// - multiplex mode shows upper digits when enabled
// - first line sense option sets upper enable
// - otherwise lower digits, second line enables
// - single line mode enables from first line
// - four line address XOR then AND
// - data lines high impedance when not enabled
// - data and point code invertible by option
// - point code 001 right, 110 left
// - six digits on 24 lines plus sign
`timescale 1ns/10ps
`include "bcd_port_map.svh"
module parallel_bcd_output_port #(
   parameter int STROBE_CYCLES = `STROBE_CYCLES
) (
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   // Meter side values, all on ref_clk
   input  wire bcd_port_pkg::meter_mode_t meter_mode,
   input  wire logic [2:0]                output_value_selector,
   input  wire bcd_port_pkg::bcd_word_t   rate_value,
   input  wire bcd_port_pkg::bcd_word_t   batch_count_value,
   input  wire bcd_port_pkg::bcd_word_t   averaged_rate,
   input  wire bcd_port_pkg::bcd_word_t   batch_number_count,
   input  wire bcd_port_pkg::bcd_word_t   total_value,
   input  wire bcd_port_pkg::bcd_word_t   time_value,
   input  wire bcd_port_pkg::dp_code_t    dp_code,
   input  wire logic                      sign_in,
   input  wire logic                      overflow_in,
   input  wire logic                      value_update,
   // Jumper options, static
   input  wire logic                      overflow_line_option,
   input  wire logic                      multiplex_option_first,
   input  wire logic                      single_line_address_option,
   input  wire logic                      multiplex_option_second,
   input  wire logic                      first_line_sense_option,
   input  wire logic                      second_line_sense_option,
   input  wire logic                      third_line_sense_option,
   input  wire logic                      fourth_line_sense_option,
   input  wire logic                      polarity_option,
   // Reader side pins on the output connector
   input  wire logic                      hold_n,
   input  wire logic                      board_select_line_one,
   input  wire logic                      board_select_line_two,
   input  wire logic                      board_select_line_four,
   input  wire logic                      board_select_line_eight,
   output logic [23:0]                    bcd_out,
   output logic [23:0]                    bcd_oe_n,
   output logic [2:0]                     dp_out,
   output logic [2:0]                     dp_oe_n,
   output logic                           sign_out,
   output logic                           sign_oe_n,
   output logic                           overflow_out,
   output logic                           overflow_oe_n,
   output logic                           data_ready_n
);
   import bcd_port_pkg::*;

   //--------------------------------------------------------------
   // Pin synchronisers
   //--------------------------------------------------------------
   logic hold_s;
   logic sel1_s;
   logic sel2_s;
   logic sel4_s;
   logic sel8_s;

   pin_sync #(.INIT(1'b1)) u_sync_hold (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     (hold_n),
      .level   (hold_s)
   );
   pin_sync #(.INIT(1'b1)) u_sync_b1 (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     (board_select_line_one),
      .level   (sel1_s)
   );
   pin_sync #(.INIT(1'b1)) u_sync_b2 (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     (board_select_line_two),
      .level   (sel2_s)
   );
   pin_sync #(.INIT(1'b1)) u_sync_b4 (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     (board_select_line_four),
      .level   (sel4_s)
   );
   pin_sync #(.INIT(1'b1)) u_sync_b8 (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     (board_select_line_eight),
      .level   (sel8_s)
   );

   //--------------------------------------------------------------
   // Value selection and latching
   //--------------------------------------------------------------
   bcd_word_t picked;
   bcd_word_t held_value;
   bcd_word_t next_held_value;
   dp_code_t  held_dp;
   dp_code_t  next_held_dp;
   logic      held_sign;
   logic      next_held_sign;
   logic      held_ovf;
   logic      next_held_ovf;
   logic      valid;
   logic      next_valid;
   logic      pending;
   logic      next_pending;
   logic      load;
   logic      enabled_sel;

   // Source mux by selector and meter mode
   always_comb begin
      enabled_sel = 1'b1;
      picked      = '0;
      case (output_value_selector)
         `SEL_RATE:  picked = (meter_mode == MODE_BATCH) ? batch_count_value : rate_value;
         `SEL_AVG:   picked = (meter_mode == MODE_BATCH) ? batch_number_count : averaged_rate;
         `SEL_TOTAL: picked = total_value;
         `SEL_TIME:  picked = time_value;
         default:    enabled_sel = 1'b0;
      endcase
   end

   // Update latch: one load moves all digits, deferred while frozen
   always_comb begin
      load            = 1'b0;
      next_pending    = pending;
      next_held_value = held_value;
      next_held_dp    = held_dp;
      next_held_sign  = held_sign;
      next_held_ovf   = held_ovf;
      next_valid      = valid && enabled_sel;
      if (!enabled_sel) begin
         next_pending = 1'b0;
      end else if (!hold_s) begin
         next_pending = pending || value_update;
      end else if (value_update || pending) begin
         load         = 1'b1;
         next_pending = 1'b0;
      end
      if (load) begin
         next_held_value = picked;
         next_held_dp    = dp_code;
         next_held_sign  = sign_in;
         next_held_ovf   = overflow_in;
         next_valid      = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         held_value <= '0;
         held_dp    <= '0;
         held_sign  <= 1'b0;
         held_ovf   <= 1'b0;
         valid      <= 1'b0;
         pending    <= 1'b0;
      end else begin
         held_value <= next_held_value;
         held_dp    <= next_held_dp;
         held_sign  <= next_held_sign;
         held_ovf   <= next_held_ovf;
         valid      <= next_valid;
         pending    <= next_pending;
      end
   end

   //--------------------------------------------------------------
   // Update strobe
   //--------------------------------------------------------------
   // Strobe never passes the polarity inversion
   strobe_timer #(.CYCLES(STROBE_CYCLES)) u_strobe (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .start    (load),
      .strobe_n (data_ready_n)
   );

   //--------------------------------------------------------------
   // Enable decode
   //--------------------------------------------------------------
   logic mux_mode;
   logic upper_en;
   logic lower_en;
   logic board_en;
   logic [11:0] upper_oe_n;
   logic [11:0] lower_oe_n;
   logic [23:0] next_bcd_out;
   logic [23:0] next_bcd_oe_n;
   logic [2:0]  next_dp_out;
   logic        next_data_oe_n;
   logic        next_sign_out;
   logic        next_ovf_out;
   logic        next_ovf_oe_n;

   always_comb begin
      mux_mode = multiplex_option_first && single_line_address_option
                 && multiplex_option_second;
      // Low active when sense option fitted
      upper_en = sel1_s ^ first_line_sense_option;
      lower_en = !upper_en && (sel2_s ^ second_line_sense_option);
      if (single_line_address_option) begin
         board_en = sel1_s ^ first_line_sense_option;
      end else begin
         board_en = (sel1_s ^ first_line_sense_option)
                    && (sel2_s ^ second_line_sense_option)
                    && (sel4_s ^ fourth_line_sense_option)
                    && (sel8_s ^ third_line_sense_option);
      end
      next_data_oe_n = !(valid && (mux_mode ? (upper_en || lower_en) : board_en));
      // Polarity inversion on data and point code only
      next_bcd_out  = polarity_option ? ~held_value : held_value;
      next_dp_out   = polarity_option ? ~held_dp : held_dp;
      next_sign_out = held_sign;
      upper_oe_n    = {12{1'b1}};
      lower_oe_n    = {12{next_data_oe_n}};
      if (mux_mode) begin
         // Upper digits ride on the lower-digit lines
         next_bcd_out[11:0] = upper_en ? next_bcd_out[23:12] : next_bcd_out[11:0];
      end else begin
         upper_oe_n = {12{next_data_oe_n}};
      end
      next_bcd_oe_n = {upper_oe_n, lower_oe_n};
      next_ovf_out  = held_ovf;
      next_ovf_oe_n = !(overflow_line_option && valid);
   end

   // Output registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bcd_out       <= '0;
         bcd_oe_n      <= {24{1'b1}};
         dp_out        <= '0;
         dp_oe_n       <= {3{1'b1}};
         sign_out      <= 1'b0;
         sign_oe_n     <= 1'b1;
         overflow_out  <= 1'b0;
         overflow_oe_n <= 1'b1;
      end else begin
         bcd_out       <= next_bcd_out;
         bcd_oe_n      <= next_bcd_oe_n;
         dp_out        <= next_dp_out;
         dp_oe_n       <= {3{next_data_oe_n}};
         sign_out      <= next_sign_out;
         sign_oe_n     <= next_data_oe_n;
         overflow_out  <= next_ovf_out;
         overflow_oe_n <= next_ovf_oe_n;
      end
   end

   //--------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------
   sequence frozen_s;
      !hold_s ##1 !hold_s;
   endsequence

   AST_FREEZE_HOLDS: assert property (@(posedge ref_clk) disable iff (!nrst)
      frozen_s |-> $stable(held_value)) else $error("value changed while frozen");
   AST_RELEASE_LOADS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (pending && hold_s && enabled_sel) |=> (held_value == $past(picked)))
      else $error("release did not load value");
   AST_STROBE_ON_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
      load |=> !data_ready_n [*8]) else $error("strobe not held low");
   AST_NO_STROBE_DISABLED: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!enabled_sel && data_ready_n) |=> data_ready_n) else $error("strobe while disabled");
   AST_OVF_OPTION: assert property (@(posedge ref_clk) disable iff (!nrst)
      !overflow_line_option |=> overflow_oe_n) else $error("overflow driven unfitted");
   AST_DISABLED_HIZ: assert property (@(posedge ref_clk) disable iff (!nrst)
      !valid |=> (&bcd_oe_n && &dp_oe_n)) else $error("data driven while invalid");
   AST_POLARITY: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!mux_mode && polarity_option) |=> (bcd_out == ~$past(held_value)))
      else $error("polarity not applied");
   AST_MUX_UPPER: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mux_mode && upper_en && !polarity_option) |=> (bcd_out[11:0] == $past(held_value[23:12])))
      else $error("upper digits not multiplexed");
   AST_RESET_STROBE: assert property (@(posedge ref_clk)
      !nrst |=> data_ready_n) else $error("strobe active after reset");
   AST_LOAD_WHOLE: assert property (@(posedge ref_clk) disable iff (!nrst)
      load |=> (held_value == $past(picked) && held_dp == $past(dp_code)))
      else $error("value not loaded whole");
   AST_POINT_POLARITY: assert property (@(posedge ref_clk) disable iff (!nrst)
      polarity_option |=> (dp_out == ~$past(held_dp))) else $error("point code not inverted");
   // Eighth-weight line mismatched against its sense option keeps the board off
   AST_ADDR_MISMATCH: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!single_line_address_option && !(sel8_s ^ third_line_sense_option)) |=> &bcd_oe_n)
      else $error("board enabled by wrong address");
endmodule : parallel_bcd_output_port

// file: verif/bcd_reader_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Reader at the far side of the output connector
// ------------------------------------------------------------
module bcd_reader_model (
   input  wire logic        freeze,
   input  wire logic [3:0]  addr,
   input  wire logic [23:0] bcd_out,
   input  wire logic [23:0] bcd_oe_n,
   output logic             hold_n,
   output logic [3:0]       sel_lines,
   output logic [23:0]      bus
);
   // Freeze line and address lines as the reader drives them
   assign hold_n    = ~freeze;
   assign sel_lines = addr;
   // Bus lines carry pull-ups, so a released line reads high
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         bus[i] = bcd_oe_n[i] ? 1'b1 : bcd_out[i];
      end
   end
endmodule : bcd_reader_model

// file: verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, seen, exp) \
   begin \
      comparisons++; \
      if ((seen) !== (exp)) begin \
         failures++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen); \
      end \
   end
module tb_top;
   import bcd_port_pkg::*;
   typedef struct {
      logic [2:0] sel; logic mode; logic mux; logic single; logic pol;
      logic [3:0] sense; logic [3:0] addr; logic [23:0] oe; logic [23:0] bus; logic drn;
   } row_t;
   // ------------------------------------------------------------
   // Ordinary cases: inputs and the outputs they should give
   // ------------------------------------------------------------
   row_t rows [17] = '{
      '{3'h1, 0, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h123456, 0},
      '{3'h1, 1, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h654321, 0},
      '{3'h2, 0, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h111111, 0},
      '{3'h2, 1, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h222222, 0},
      '{3'h3, 0, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h333333, 0},
      '{3'h4, 1, 0, 0, 0, 4'hF, 4'h0, 24'h0, 24'h444444, 0},
      '{3'h1, 0, 0, 0, 0, 4'hF, 4'h1, 24'hFFFFFF, 24'hFFFFFF, 0},
      '{3'h3, 0, 0, 0, 0, 4'h0, 4'hF, 24'h0, 24'h333333, 0},
      '{3'h3, 0, 0, 0, 1, 4'hF, 4'h0, 24'h0, 24'hCCCCCC, 0},
      '{3'h1, 0, 0, 1, 0, 4'h1, 4'hE, 24'h0, 24'h123456, 0},
      '{3'h1, 0, 0, 1, 0, 4'h1, 4'h1, 24'hFFFFFF, 24'hFFFFFF, 0},
      '{3'h1, 0, 1, 1, 0, 4'h3, 4'h2, 24'hFFF000, 24'hFFF123, 0},
      '{3'h1, 0, 1, 1, 0, 4'h3, 4'h1, 24'hFFF000, 24'hFFF456, 0},
      '{3'h1, 0, 1, 1, 0, 4'h3, 4'h3, 24'hFFFFFF, 24'hFFFFFF, 0},
      '{3'h0, 0, 0, 0, 0, 4'hF, 4'h0, 24'hFFFFFF, 24'hFFFFFF, 1},
      '{3'h5, 0, 0, 0, 0, 4'hF, 4'h0, 24'hFFFFFF, 24'hFFFFFF, 1},
      '{3'h3, 0, 0, 0, 0, 4'h4, 4'h7, 24'h0, 24'h333333, 0}
   };
   logic        ref_clk = 1'b0;
   logic        nrst, value_update, sign_in, overflow_in, pol, freeze;
   logic        mux, single, overflow_line_option;
   meter_mode_t meter_mode;
   dp_code_t    dp;
   logic [2:0]  sel;
   logic [3:0]  sense, addr, sel_lines;
   bcd_word_t   rate_value;
   logic [23:0] bcd_out, bcd_oe_n, bus;
   logic [2:0]  dp_out, dp_oe_n;
   logic        sign_out, sign_oe_n, overflow_out, overflow_oe_n, data_ready_n, hold_n;
   int          failures, comparisons, cycles, n, low_seen;
   parallel_bcd_output_port #(.STROBE_CYCLES(8)) i_parallel_bcd_output_port (
      .ref_clk(ref_clk), .nrst(nrst), .meter_mode(meter_mode),
      .output_value_selector(sel), .rate_value(rate_value), .batch_count_value(24'h654321),
      .averaged_rate(24'h111111), .batch_number_count(24'h222222),
      .total_value(24'h333333), .time_value(24'h444444), .dp_code(dp),
      .sign_in(sign_in), .overflow_in(overflow_in), .value_update(value_update),
      .overflow_line_option(overflow_line_option), .multiplex_option_first(mux),
      .single_line_address_option(single), .multiplex_option_second(mux),
      .first_line_sense_option(sense[0]), .second_line_sense_option(sense[1]),
      .third_line_sense_option(sense[2]), .fourth_line_sense_option(sense[3]),
      .polarity_option(pol), .hold_n(hold_n), .board_select_line_one(sel_lines[0]),
      .board_select_line_two(sel_lines[1]), .board_select_line_four(sel_lines[2]),
      .board_select_line_eight(sel_lines[3]), .bcd_out(bcd_out), .bcd_oe_n(bcd_oe_n),
      .dp_out(dp_out), .dp_oe_n(dp_oe_n), .sign_out(sign_out), .sign_oe_n(sign_oe_n),
      .overflow_out(overflow_out), .overflow_oe_n(overflow_oe_n),
      .data_ready_n(data_ready_n));
   bcd_reader_model i_bcd_reader_model (
      .freeze(freeze), .addr(addr), .bcd_out(bcd_out), .bcd_oe_n(bcd_oe_n),
      .hold_n(hold_n), .sel_lines(sel_lines), .bus(bus));
   // Clock of 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         report_and_stop();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // Set the static options and the reader lines, then let the pin syncs settle
   task automatic apply(input row_t r);
      @(negedge ref_clk);
      sel = r.sel;
      meter_mode = meter_mode_t'(r.mode);
      mux = r.mux;
      single = r.single;
      pol = r.pol;
      sense = r.sense;
      addr = r.addr;
      repeat (8) @(negedge ref_clk);
   endtask : apply
   // One-cycle new value pulse from the meter
   task automatic pulse;
      value_update = 1'b1;
      @(negedge ref_clk);
      value_update = 1'b0;
   endtask : pulse
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, value_update, pol, freeze, mux, single} = '0;
      meter_mode = MODE_RATE_SQRT;
      dp = 3'h6;
      {sign_in, overflow_in, overflow_line_option} = 3'h7;
      {sel, sense, addr} = '0;
      rate_value = 24'h123456;
      repeat (12) @(negedge ref_clk);
      `CHK("oe in reset", bcd_oe_n, 24'hFFFFFF);
      `CHK("ready in reset", data_ready_n, 1'b1);
      nrst = 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         apply(rows[i]);
         pulse();
         repeat (3) @(negedge ref_clk);
         `CHK("oe", bcd_oe_n, rows[i].oe);
         `CHK("bus", bus, rows[i].bus);
         `CHK("ready", data_ready_n, rows[i].drn);
         `CHK("point oe", dp_oe_n, {3{rows[i].oe[0]}});
         `CHK("sign oe", sign_oe_n, rows[i].oe[0]);
         if (rows[i].oe == 24'h0) begin
            `CHK("point", dp_out, rows[i].pol ? 3'h1 : 3'h6);
            `CHK("sign", sign_out, 1'b1);
         end
         $display("test row %0d done", i);
      end
      // Strobe width with negative-true data
      apply(rows[8]);
      pulse();
      // The pulse task returns on the first low sample, which is counted here
      n = (data_ready_n === 1'b0);
      repeat (20) begin
         @(negedge ref_clk);
         n += (data_ready_n === 1'b0);
      end
      `CHK("strobe length", n, 8);
      `CHK("bus inverted", bus, 24'hCCCCCC);
      $display("test strobe done");
      // Freeze holds the old value, release refreshes it in one step
      apply(rows[0]);
      pulse();
      freeze = 1'b1;
      repeat (8) @(negedge ref_clk);
      rate_value = 24'h987654;
      pulse();
      repeat (4) @(negedge ref_clk);
      `CHK("frozen bus", bus, 24'h123456);
      `CHK("frozen ready", data_ready_n, 1'b1);
      freeze = 1'b0;
      low_seen = 0;
      repeat (10) begin
         @(negedge ref_clk);
         `CHK("whole value", bus === 24'h123456 || bus === 24'h987654, 1'b1);
         low_seen |= (data_ready_n === 1'b0);
      end
      `CHK("released bus", bus, 24'h987654);
      `CHK("released strobe", low_seen, 1);
      $display("test freeze done");
      // Overflow line driven only with its option fitted
      {overflow_in, sign_in, dp} = {1'b0, 1'b0, 3'h1};
      pulse();
      repeat (3) @(negedge ref_clk);
      `CHK("overflow low", overflow_out, 1'b0);
      `CHK("sign low", sign_out, 1'b0);
      `CHK("point right", dp_out, 3'h1);
      {overflow_in, sign_in} = 2'h3;
      pulse();
      repeat (3) @(negedge ref_clk);
      `CHK("overflow oe", overflow_oe_n, 1'b0);
      `CHK("overflow", overflow_out, 1'b1);
      overflow_line_option = 1'b0;
      repeat (4) @(negedge ref_clk);
      `CHK("overflow off", overflow_oe_n, 1'b1);
      $display("test overflow done");
      // Reset mid-run drops the value until the next update
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK("oe after reset", bcd_oe_n, 24'hFFFFFF);
      `CHK("ready after reset", data_ready_n, 1'b1);
      $display("test reset again done");
      report_and_stop();
   end
endmodule : tb_top
